// File: dps_host.sv
// Debugger host model driving the test clock and mode-select pins.
`timescale 1ns/100ps
module dps_host (
    // Clock
    input  wire logic ref_clk,
    // Host pins
    output logic      tck,
    output logic      tms
);
    // The test clock stands low between bits, as a real host leaves it.
    initial begin
        tck = 1'b0;
        tms = 1'b1;
    end
    task automatic clk_bit(input logic b);
        @(posedge ref_clk) tms <= b;
        repeat (3) @(posedge ref_clk);
        tck <= 1'b1;
        repeat (4) @(posedge ref_clk);
        tck <= 1'b0;
    endtask : clk_bit
    // A leading low bit breaks any earlier high run; after IDLE_MIN or more highs, or in the middle of a code, the selector takes it as a code bit.
    task automatic run(input int pre, input logic [15:0] code, input int post);
        clk_bit(1'b0);
        repeat (pre) clk_bit(1'b1);
        for (int i = 15; i >= 0; i--) clk_bit(code[i]);
        repeat (post) clk_bit(1'b1);
    endtask : run
endmodule : dps_host

// File: dps_map.svh
// Constants for the debug port protocol selector.
`ifndef DPS_MAP_SVH
`define DPS_MAP_SVH
`define DPS_SWITCH_CODE   16'h79E7
`define DPS_CODE_BITS     16
`define DPS_IDLE_MIN      51
`define DPS_IDLE_CNT_W    7
`endif

// File: dps_pkg.sv
// Types shared by the debug port protocol selector.
package dps_pkg;
    typedef enum logic [1:0] {
        DPS_PRE_IDLE  = 2'b00,
        DPS_CODE      = 2'b01,
        DPS_POST_IDLE = 2'b10,
        DPS_TWO_WIRE  = 2'b11
    } dps_state_e;

    typedef struct packed {
        logic tck;
        logic tms;
        logic tdi;
        logic trst_n;
    } dps_scan_in_s;

    typedef struct packed {
        logic tdo;
        logic tdo_oe;
    } dps_scan_out_s;
endpackage : dps_pkg

// File: dps_select.sv
// Combined debug port selector: scan-chain by default, two-wire after the switch sequence.
`timescale 1ns/100ps
`include "dps_map.svh"
module dps_select #(
    parameter int IDLE_MIN = `DPS_IDLE_MIN
) (
    // Clock and reset
    input  wire logic                   ref_clk,
    input  wire logic                   srst,
    // Debug pins from the host, and data-out and trace sources from the core
    input  wire dps_pkg::dps_scan_in_s  pin_in,
    input  wire logic                   tdo_core,
    input  wire logic                   trace_core,
    input  wire logic                   trace_en,
    // Two-wire data pin drive
    input  wire logic                   two_wire_data_out,
    input  wire logic                   two_wire_data_drive,
    output logic                        two_wire_data_o,
    output logic                        two_wire_data_oe,
    // Test-data-out pin
    output dps_pkg::dps_scan_out_s      pin_out,
    // Towards the two ports and the boundary-scan port
    output logic                        scan_chain_en,
    output logic                        two_wire_en,
    output logic                        two_wire_clock_rise,
    output logic                        two_wire_data_in,
    output dps_pkg::dps_scan_in_s       scan_chain_in,
    output logic                        bscan_tms
);
    dps_pkg::dps_scan_in_s      pins;
    dps_pkg::dps_state_e        state;
    logic                       tck_d;
    logic                       tck_rise;
    logic [`DPS_CODE_BITS-1:0]  window;
    logic [`DPS_IDLE_CNT_W-1:0] ones;
    logic [`DPS_IDLE_CNT_W-1:0] post_ones;
    logic [4:0]                 code_cnt;

    // Pins cross from the host's clock, so every one passes two flops first.
    dps_sync #(.WIDTH(4)) u_sync (
        .ref_clk  (ref_clk),
        .srst     (srst),
        .async_in (pin_in),
        .sync_out (pins)
    );

    // Test clock is sampled, not used as a clock; its period must span several ref_clk edges.
    always_ff @(posedge ref_clk) begin
        if (srst) begin
            tck_d <= 1'b0;
        end else begin
            tck_d <= pins.tck;
        end
    end

    assign tck_rise = pins.tck & ~tck_d;

    // Shift window of mode-select samples, one per test clock rising edge.
    always_ff @(posedge ref_clk) begin
        if (srst) begin
            window <= '0;
        end else if (tck_rise) begin
            window <= {window[`DPS_CODE_BITS-2:0], pins.tms};
        end
    end

    // Run length of high samples, saturating.
    always_ff @(posedge ref_clk) begin
        if (srst) begin
            ones <= '0;
        end else if (tck_rise) begin
            if (!pins.tms) begin
                ones <= '0;
            end else if (ones != {`DPS_IDLE_CNT_W{1'b1}}) begin
                ones <= ones + 1'b1;
            end
        end
    end

    // Post-code run counts only highs after the code; the code's own trailing ones do not count.
    always_ff @(posedge ref_clk) begin
        if (srst) begin
            post_ones <= '0;
        end else if (state != dps_pkg::DPS_POST_IDLE) begin
            post_ones <= '0;
        end else if (tck_rise && pins.tms && post_ones != {`DPS_IDLE_CNT_W{1'b1}}) begin
            post_ones <= post_ones + 1'b1;
        end
    end

    // Sequence tracker; two-wire mode holds until reset.
    always_ff @(posedge ref_clk) begin
        if (srst) begin
            state    <= dps_pkg::DPS_PRE_IDLE;
            code_cnt <= '0;
        end else if (tck_rise) begin
            case (state)
                dps_pkg::DPS_PRE_IDLE: begin
                    // The code opens with a zero right after the high run.
                    if (!pins.tms && ones >= IDLE_MIN[`DPS_IDLE_CNT_W-1:0]) begin
                        state    <= dps_pkg::DPS_CODE;
                        code_cnt <= 5'h01;
                    end
                end
                dps_pkg::DPS_CODE: begin
                    if (code_cnt == 5'(`DPS_CODE_BITS - 1)) begin
                        if ({window[`DPS_CODE_BITS-2:0], pins.tms} == `DPS_SWITCH_CODE) begin
                            state <= dps_pkg::DPS_POST_IDLE;
                        end else begin
                            state <= dps_pkg::DPS_PRE_IDLE;
                        end
                        code_cnt <= '0;
                    end else begin
                        code_cnt <= code_cnt + 5'h01;
                    end
                end
                dps_pkg::DPS_POST_IDLE: begin
                    if (!pins.tms) begin
                        state <= dps_pkg::DPS_PRE_IDLE;
                    end else if (post_ones >= IDLE_MIN[`DPS_IDLE_CNT_W-1:0] - 1'b1) begin
                        state <= dps_pkg::DPS_TWO_WIRE;
                    end
                end
                dps_pkg::DPS_TWO_WIRE: begin
                    state <= dps_pkg::DPS_TWO_WIRE;
                end
                default: begin
                    state <= dps_pkg::DPS_PRE_IDLE;
                end
            endcase
        end
    end

    assign two_wire_en   = (state == dps_pkg::DPS_TWO_WIRE);
    assign scan_chain_en = ~two_wire_en;

    // Two-wire port reuses the test clock and mode-select pins.
    assign two_wire_clock_rise = two_wire_en & tck_rise;
    assign two_wire_data_in    = pins.tms;

    // Data outputs come from flops; the bidirectional line is only driven in two-wire mode.
    always_ff @(posedge ref_clk) begin
        if (srst) begin
            two_wire_data_o  <= 1'b0;
            two_wire_data_oe <= 1'b0;
        end else begin
            two_wire_data_o  <= two_wire_data_out;
            two_wire_data_oe <= two_wire_en & two_wire_data_drive;
        end
    end

    // Test-data-out carries trace only in two-wire mode, so the host never sees both at once.
    always_ff @(posedge ref_clk) begin
        if (srst) begin
            pin_out <= '0;
        end else if (two_wire_en) begin
            pin_out.tdo    <= trace_core;
            pin_out.tdo_oe <= trace_en;
        end else begin
            pin_out.tdo    <= tdo_core;
            pin_out.tdo_oe <= 1'b1;
        end
    end

    // Parked inputs keep the idle scan-chain logic quiet.
    always_ff @(posedge ref_clk) begin
        if (srst) begin
            scan_chain_in <= '{tck: 1'b0, tms: 1'b1, tdi: 1'b1, trst_n: 1'b1};
        end else if (two_wire_en) begin
            scan_chain_in <= '{tck: 1'b0, tms: 1'b1, tdi: 1'b1, trst_n: 1'b1};
        end else begin
            scan_chain_in <= pins;
        end
    end

    // Boundary-scan select is held high so wire traffic cannot walk that port's state.
    always_ff @(posedge ref_clk) begin
        if (srst) begin
            bscan_tms <= 1'b1;
        end else if (two_wire_en) begin
            bscan_tms <= 1'b1;
        end else begin
            bscan_tms <= pins.tms;
        end
    end
endmodule : dps_select

// File: dps_select_properties.sv
// Concurrent checks on the ports of the debug port selector.
`timescale 1ns/100ps
module dps_select_chk (
    // Clock and reset
    input  wire logic                   ref_clk,
    input  wire logic                   srst,
    // Watched pins
    input  wire logic                   tdo_core,
    input  wire logic                   trace_en,
    input  wire logic                   two_wire_data_oe,
    input  wire dps_pkg::dps_scan_out_s pin_out,
    input  wire logic                   scan_chain_en,
    input  wire logic                   two_wire_en,
    input  wire logic                   two_wire_clock_rise,
    input  wire logic                   bscan_tms
);
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (srst);
    a_reset_scan: assert property ($fell(srst) |-> scan_chain_en && !two_wire_en)
        else $error("scan mode missing after reset");
    a_mode_exclusive: assert property (scan_chain_en != two_wire_en)
        else $error("mode enables not exclusive");
    a_two_wire_holds: assert property (two_wire_en |=> two_wire_en)
        else $error("two-wire mode dropped");
    a_drive_gated: assert property (scan_chain_en |-> !two_wire_data_oe)
        else $error("data pin driven in scan mode");
    a_clock_gated: assert property (scan_chain_en |-> !two_wire_clock_rise)
        else $error("wire clock pulse in scan mode");
    a_scan_tdo: assert property (scan_chain_en && $past(scan_chain_en) && !$past(srst)
        |-> pin_out.tdo == $past(tdo_core) && pin_out.tdo_oe)
        else $error("scan data-out wrong");
    a_trace_oe: assert property (two_wire_en && $past(two_wire_en)
        |-> pin_out.tdo_oe == $past(trace_en))
        else $error("trace enable wrong");
    a_bscan_forced: assert property (two_wire_en && $past(two_wire_en) |-> bscan_tms)
        else $error("boundary-scan select not forced");
    c_switch: cover property ($rose(two_wire_en));
    c_wire_clock: cover property (two_wire_clock_rise);
    c_trace: cover property (two_wire_en && pin_out.tdo_oe);
endmodule : dps_select_chk
bind dps_select dps_select_chk u_chk (.ref_clk(ref_clk), .srst(srst), .tdo_core(tdo_core),
    .trace_en(trace_en), .two_wire_data_oe(two_wire_data_oe), .pin_out(pin_out),
    .scan_chain_en(scan_chain_en), .two_wire_en(two_wire_en),
    .two_wire_clock_rise(two_wire_clock_rise), .bscan_tms(bscan_tms));

// File: dps_sync.sv
// Two-stage synchroniser for a group of pin inputs.
`timescale 1ns/100ps
module dps_sync #(
    parameter int WIDTH = 4
) (
    // Clock and reset
    input  wire logic             ref_clk,
    input  wire logic             srst,
    // Data
    input  wire logic [WIDTH-1:0] async_in,
    output logic      [WIDTH-1:0] sync_out
);
    logic [WIDTH-1:0] stage1;

    always_ff @(posedge ref_clk) begin
        if (srst) begin
            stage1   <= '0;
            sync_out <= '0;
        end else begin
            stage1   <= async_in;
            sync_out <= stage1;
        end
    end
endmodule : dps_sync

// File: tb.sv
// Self-checking bench for the debug port selector.
`timescale 1ns/100ps
`include "dps_map.svh"
`define CHK(n, e, a) begin n_checks++; if ((a) !== (e)) begin err_total++; \
    $display("mismatch %s expected %h seen %h", n, e, a); end end
module tb;
    localparam int          IDLE = 4;
    logic                   ref_clk, srst, tck, tms, tdi, trst_n, tdo_core;
    logic                   trace_core, trace_en, wdo, wdd, o, oe, scan_en, tw_en, rise, bscan;
    dps_pkg::dps_scan_out_s pout;
    integer                 seed = 32'hdd95;
    int                     err_total, n_checks, cnt;
    // The shared pin follows the selector while it drives, else the host.
    wire logic              pin_tms = oe ? o : tms;
    dps_host host (.ref_clk(ref_clk), .tck(tck), .tms(tms));
    dps_select #(.IDLE_MIN(IDLE)) dut (.ref_clk(ref_clk), .srst(srst),
        .pin_in({tck, pin_tms, tdi, trst_n}), .tdo_core(tdo_core), .trace_core(trace_core),
        .trace_en(trace_en), .two_wire_data_out(wdo), .two_wire_data_drive(wdd),
        .two_wire_data_o(o), .two_wire_data_oe(oe), .pin_out(pout), .scan_chain_en(scan_en),
        .two_wire_en(tw_en), .two_wire_clock_rise(rise), .two_wire_data_in(),
        .scan_chain_in(), .bscan_tms(bscan));
    initial begin
        ref_clk = 1'b0;
        srst = 1'b1;
        {tdi, trst_n, tdo_core, trace_core, trace_en, wdo, wdd} = 7'h00;
        forever #10 ref_clk = ~ref_clk;
    end
    always @(posedge ref_clk) begin
        {tdi, trst_n, tdo_core, trace_core, trace_en, wdo, wdd} <= 7'($random(seed));
    end
    task automatic give_verdict();
        $display("checks %0d mismatches %0d", n_checks, err_total);
        if (err_total == 0 && n_checks > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask : give_verdict
    // The answer lands a few cycles after the last test clock rise.
    task automatic try(input int pre, input logic [15:0] code, input int post, input logic e);
        host.run(pre, code, post);
        repeat (8) @(negedge ref_clk);
        `CHK("two_wire_en", e, tw_en)
        $display("test sequence done");
    endtask : try
    task automatic reset_check();
        @(posedge ref_clk) srst <= 1'b1;
        repeat (3) @(posedge ref_clk);
        srst <= 1'b0;
        repeat (4) @(negedge ref_clk);
        `CHK("scan_chain_en", 1'b1, scan_en)
        `CHK("tdo_oe", 1'b1, pout.tdo_oe)
        $display("test reset done");
    endtask : reset_check
    initial begin
        repeat (20) @(posedge ref_clk);
        reset_check();
        try(IDLE - 1, `DPS_SWITCH_CODE, IDLE, 1'b0);
        repeat (2) try(IDLE + ($random(seed) & 3),
            `DPS_SWITCH_CODE ^ (16'h0001 << ($random(seed) & 15)), IDLE, 1'b0);
        try(IDLE, `DPS_SWITCH_CODE, IDLE - 1, 1'b0);
        try(IDLE, `DPS_SWITCH_CODE, IDLE, 1'b1);
        `CHK("scan_chain_en", 1'b0, scan_en)
        `CHK("bscan_tms", 1'b1, bscan)
        cnt = 0;
        fork
            host.clk_bit(1'b1);
            repeat (12) begin @(negedge ref_clk); cnt += rise; end
        join
        `CHK("clock_rise", 1, cnt)
        reset_check();
        give_verdict();
    end
endmodule : tb
